// >>> include/rdrb_pkg.sv
// Constants, field layout and helpers of the render debug register bank
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package rdrb_pkg;

  // Register byte offsets
  localparam logic [15:0] OFF_FLUSH_FSM   = 16'h2200;
  localparam logic [15:0] OFF_FLUSH_FLAG  = 16'h2204;
  localparam logic [15:0] OFF_FLUSH_TRACK = 16'h2208;
  localparam logic [15:0] OFF_CMD_WORD    = 16'h220C;
  localparam logic [15:0] OFF_CMD_VALID   = 16'h2210;
  localparam logic [15:0] OFF_PREEMPT     = 16'h2214;
  localparam logic [15:0] OFF_CLK_CMP_LO  = 16'h2360;
  localparam logic [15:0] OFF_CLK_CMP_HI  = 16'h2364;
  localparam logic [15:0] OFF_DRAW_PRESET = 16'h2450;
  localparam logic [15:0] OFF_VF_SCRATCH  = 16'h2470;
  localparam logic [15:0] OFF_ECO_SCRATCH = 16'h21D0;

  // Values after reset
  localparam logic [9:0]  RST_PREEMPT = 10'h000;
  localparam logic [63:0] RST_CLK_CMP = 64'h0000000000000000;
  localparam logic [23:0] RST_DRAW    = 24'h000000;
  localparam logic [15:0] RST_VF      = 16'h0000;
  localparam logic [15:0] RST_ECO     = 16'h0000;

  // Field positions
  localparam int MASK_SHIFT      = 16;
  localparam int VF_SNAP_BIT     = 15;
  localparam int VF_INHIBIT_BIT  = 2;
  localparam int VF_OFC_BIT      = 1;
  localparam int ECO_RCC_CG_BIT  = 8;
  localparam int ECO_MEMORY_WRITEBACK_UNIT_CG_BIT = 7;
  localparam int ECO_VFE_FIX_BIT = 5;
  localparam int ECO_CBUF_BIT    = 4;
  localparam int ECO_SCR_FIX_BIT = 3;
  localparam logic [15:0] VF_IMPL  = 16'h0006;
  localparam logic [15:0] ECO_IMPL = 16'h01B8;

  // Timing and sizes
  localparam int CLK_PERIOD_NS = 50;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] SCR_MAX_FIX_KB  = 9'h100;
  localparam logic [8:0] SCR_MAX_BASE_KB = 9'h00C;

  // Index of a single set bit, or all ones when not exactly one is set
  function automatic logic [2:0] enc_onehot(input logic [7:0] v);
    logic [2:0] idx;
    logic [3:0] cnt;
    idx = 3'h0;
    cnt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        idx = 3'(i);
        cnt = cnt + 4'h1;
      end
    end
    return (cnt == 4'h1) ? idx : 3'h7;
  endfunction

  // Masked update of a low half: only bits with mask set and implemented move
  function automatic logic [15:0] mask_merge(input logic [15:0] old,
                                             input logic [31:0] wdata,
                                             input logic [15:0] impl);
    logic [15:0] sel;
    sel = wdata[31:16] & impl;
    return (old & ~sel) | (wdata[15:0] & sel);
  endfunction

endpackage

// >>> include/rdrb_ctl_if.sv
// Carrier between the register bank and its timing engines
`timescale 1ns/1ns
interface rdrb_ctl_if;
  logic [9:0]  delay_us;
  logic        submit;
  logic        honored;
  logic [63:0] cmp_val;
  logic        cmp_wr;
  logic        clk_stop;
  logic [63:0] tick_cnt;

  modport bank (output delay_us, submit, cmp_val, cmp_wr,
                input  honored, clk_stop, tick_cnt);
  modport gate (input delay_us, submit, output honored);
  modport stop (input cmp_val, cmp_wr, output clk_stop, tick_cnt);
endinterface

// >>> design/rdrb_preempt_gate.sv
// Minimum spacing gate for run-list submissions
`timescale 1ns/1ns
module rdrb_preempt_gate (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // Control
  rdrb_ctl_if.gate  ctl
);
  logic [4:0]  pre_q;      // Microsecond prescaler
  logic [10:0] elapsed_q;  // Whole microseconds since last honored, saturating
  logic        pending_q;
  logic        honored_q;
  logic        go;
  logic        tick;

  // Elapsed must strictly exceed the delay; zero delay never waits
  assign tick = (pre_q == 5'(rdrb_pkg::CYC_PER_US - 1));
  assign go   = (pending_q | ctl.submit) &
                ((ctl.delay_us == 10'h000) | (elapsed_q > {1'b0, ctl.delay_us}));
  assign ctl.honored = honored_q;

  // Start saturated so the first submission after reset is not held
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pre_q     <= 5'h00;
      elapsed_q <= 11'h7FF;
      pending_q <= 1'b0;
      honored_q <= 1'b0;
    end else begin
      pre_q     <= (go | tick) ? 5'h00 : pre_q + 5'h01;
      elapsed_q <= go ? 11'h000 : ((tick & ~&elapsed_q) ? elapsed_q + 11'h001 : elapsed_q);
      pending_q <= (pending_q | ctl.submit) & ~go;
      honored_q <= go;
    end
  end
endmodule

// >>> design/rdrb_clk_stop.sv
// Core clock tick counter with stop compare
`timescale 1ns/1ns
module rdrb_clk_stop (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // Control
  rdrb_ctl_if.stop  ctl
);
  logic [63:0] cnt_q;
  logic        stop_q;
  logic        hit;

  // A zero compare means the stop is unarmed, so reset does not freeze the core
  assign hit = (ctl.cmp_val != 64'h0) & (cnt_q == ctl.cmp_val);
  assign ctl.clk_stop = stop_q;
  assign ctl.tick_cnt = cnt_q;

  // Write restarts counting; the stop holds until the next write
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_q  <= 64'h0;
      stop_q <= 1'b0;
    end else if (ctl.cmp_wr) begin
      cnt_q  <= 64'h0;
      stop_q <= 1'b0;
    end else begin
      cnt_q  <= (stop_q | hit) ? cnt_q : cnt_q + 64'h1;
      stop_q <= stop_q | hit;
    end
  end
endmodule

// >>> design/rdrb_top.sv
// Render debug register bank: registers, live debug views and control outputs
`timescale 1ns/1ns
module rdrb_top (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // Register access port
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  // Flush state machines: one-hot state vectors, plus two 4-bit codes passed through as they are
  input  wire logic [6:0]  flush_fifo_state_i,
  input  wire logic [5:0]  ctl3d_flush_state_i,
  input  wire logic [3:0]  unified_return_buffer_state_i,
  input  wire logic [3:0]  urb_entry_code_i,
  input  wire logic [3:0]  flush_next_code_i,
  // Flush flags and tracking
  input  wire logic [16:0] flush_flags_i,
  input  wire logic [12:0] flush_track_i,
  // Command parser
  input  wire logic [31:0] cmd_word_i,
  input  wire logic        cmd_valid_i,
  // Run list
  input  wire logic        run_list_submit_i,
  output logic             run_list_go_o,
  // Core clock stop
  output logic             core_clk_stop_o,
  // Vertex fetch
  input  wire logic        elem_seq_or_primid_i,
  output logic [23:0]      draw_count_preset_o,
  output logic             snapshot_resume_o,
  output logic             vc_implicit_inhibit_o,
  output logic             vertex_result_cache_disable_o,
  output logic             fetch_bypass_cache_o,
  // Engineering scratch-pad controls
  output logic             render_cache_ctl_cg_en_o,
  output logic             memory_writeback_unit_cg_en_o,
  output logic             video_front_end_unit_fix_o,
  output logic             const_buf_ctx_excl_o,
  output logic             thread_dispatch_unit_scr_fix_o,
  output logic [8:0]       scratch_max_kb_o
);

  //--------------------------------------------------------------------
  // Carrier and engines
  //--------------------------------------------------------------------
  rdrb_ctl_if ctl ();

  rdrb_preempt_gate u_gate (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ctl        (ctl.gate)
  );

  rdrb_clk_stop u_stop (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ctl        (ctl.stop)
  );

  //--------------------------------------------------------------------
  // Software-held registers
  //--------------------------------------------------------------------
  logic [9:0]  preempt_q;
  logic [63:0] clk_cmp_q;
  logic [23:0] draw_q;
  logic [15:0] vf_q;
  logic [15:0] eco_q;
  logic        snap_q;
  logic        vc_dis_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic [8:0]  scr_max_q;

  //--------------------------------------------------------------------
  // Address decode
  //--------------------------------------------------------------------
  wire hit_fsm    = (reg_addr_i == rdrb_pkg::OFF_FLUSH_FSM);
  wire hit_flag   = (reg_addr_i == rdrb_pkg::OFF_FLUSH_FLAG);
  wire hit_track  = (reg_addr_i == rdrb_pkg::OFF_FLUSH_TRACK);
  wire hit_cmdw   = (reg_addr_i == rdrb_pkg::OFF_CMD_WORD);
  wire hit_cmdv   = (reg_addr_i == rdrb_pkg::OFF_CMD_VALID);
  wire hit_pre    = (reg_addr_i == rdrb_pkg::OFF_PREEMPT);
  wire hit_cmp_lo = (reg_addr_i == rdrb_pkg::OFF_CLK_CMP_LO);
  wire hit_cmp_hi = (reg_addr_i == rdrb_pkg::OFF_CLK_CMP_HI);
  wire hit_draw   = (reg_addr_i == rdrb_pkg::OFF_DRAW_PRESET);
  wire hit_vf     = (reg_addr_i == rdrb_pkg::OFF_VF_SCRATCH);
  wire hit_eco    = (reg_addr_i == rdrb_pkg::OFF_ECO_SCRATCH);

  // Write strobes; the flush debug registers get none, so writes there vanish
  wire wr_pre  = reg_wr_i & hit_pre;
  wire wr_lo   = reg_wr_i & hit_cmp_lo;
  wire wr_hi   = reg_wr_i & hit_cmp_hi;
  wire wr_draw = reg_wr_i & hit_draw;
  wire wr_vf   = reg_wr_i & hit_vf;
  wire wr_eco  = reg_wr_i & hit_eco;
  wire wr_snap = wr_vf & reg_wdata_i[rdrb_pkg::MASK_SHIFT + rdrb_pkg::VF_SNAP_BIT] &
                 reg_wdata_i[rdrb_pkg::VF_SNAP_BIT];

  //--------------------------------------------------------------------
  // Live debug views
  //--------------------------------------------------------------------
  wire [2:0] fifo_code = rdrb_pkg::enc_onehot({1'b0, flush_fifo_state_i});
  wire [2:0] c3d_code  = rdrb_pkg::enc_onehot({2'b00, ctl3d_flush_state_i});
  wire [2:0] urb_full  = rdrb_pkg::enc_onehot({4'h0, unified_return_buffer_state_i});
  wire [1:0] urb_code  = urb_full[1:0];

  // Sampled every cycle from the flush and command parser inputs, never stored
  wire [31:0] v_fsm   = {16'h0000, fifo_code, c3d_code, urb_code,
                         urb_entry_code_i, flush_next_code_i};
  wire [31:0] v_flag  = {15'h0000, flush_flags_i};
  wire [31:0] v_track = {19'h00000, flush_track_i};
  wire [31:0] v_cmdw  = cmd_word_i;
  wire [31:0] v_cmdv  = {31'h00000000, cmd_valid_i};

  // Masks never read back; the snapshot bit is a write-only pulse
  wire [31:0] v_pre   = {22'h000000, preempt_q};
  wire [31:0] v_draw  = {8'h00, draw_q};
  wire [31:0] v_vf    = {16'h0000, vf_q};
  wire [31:0] v_eco   = {16'h0000, eco_q};

  //--------------------------------------------------------------------
  // Read selection; unmapped addresses read zero
  //--------------------------------------------------------------------
  wire [31:0] rd_mux =
    hit_fsm    ? v_fsm :
    hit_flag   ? v_flag :
    hit_track  ? v_track :
    hit_cmdw   ? v_cmdw :
    hit_cmdv   ? v_cmdv :
    hit_pre    ? v_pre :
    hit_cmp_lo ? clk_cmp_q[31:0] :
    hit_cmp_hi ? clk_cmp_q[63:32] :
    hit_draw   ? v_draw :
    hit_vf     ? v_vf :
    hit_eco    ? v_eco : 32'h00000000;

  //--------------------------------------------------------------------
  // Register updates
  //--------------------------------------------------------------------
  // Preemption delay and draw preset: plain stores, reserved bits dropped
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      preempt_q <= rdrb_pkg::RST_PREEMPT;
      draw_q    <= rdrb_pkg::RST_DRAW;
    end else begin
      if (wr_pre) begin
        preempt_q <= reg_wdata_i[9:0];
      end
      if (wr_draw) begin
        draw_q <= reg_wdata_i[23:0];
      end
    end
  end

  // Compare words move only on software writes; no restore path reaches them
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      clk_cmp_q <= rdrb_pkg::RST_CLK_CMP;
    end else begin
      if (wr_lo) begin
        clk_cmp_q[31:0] <= reg_wdata_i;
      end
      if (wr_hi) begin
        clk_cmp_q[63:32] <= reg_wdata_i;
      end
    end
  end

  // Scratch pads: masked writes, implemented bits only
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      vf_q  <= rdrb_pkg::RST_VF;
      eco_q <= rdrb_pkg::RST_ECO;
    end else begin
      if (wr_vf) begin
        vf_q <= rdrb_pkg::mask_merge(vf_q, reg_wdata_i, rdrb_pkg::VF_IMPL);
      end
      if (wr_eco) begin
        eco_q <= rdrb_pkg::mask_merge(eco_q, reg_wdata_i, rdrb_pkg::ECO_IMPL);
      end
    end
  end

  // Snapshot release pulse and implicit cache disable
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      snap_q   <= 1'b0;
      vc_dis_q <= 1'b0;
    end else begin
      snap_q   <= wr_snap;
      vc_dis_q <= elem_seq_or_primid_i & ~vf_q[rdrb_pkg::VF_INHIBIT_BIT];
    end
  end

  // Scratch size limit follows the fix bit; base alignment is software's job
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      scr_max_q <= rdrb_pkg::SCR_MAX_BASE_KB;
    end else begin
      scr_max_q <= eco_q[rdrb_pkg::ECO_SCR_FIX_BIT] ? rdrb_pkg::SCR_MAX_FIX_KB
                                                    : rdrb_pkg::SCR_MAX_BASE_KB;
    end
  end

  // Read answer one cycle after the strobe; data is zero when idle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_q  <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= reg_rd_i ? rd_mux : 32'h00000000;
      rvalid_q <= reg_rd_i;
    end
  end

  //--------------------------------------------------------------------
  // Engine hookup and outputs
  //--------------------------------------------------------------------
  assign ctl.delay_us = preempt_q;
  assign ctl.submit   = run_list_submit_i;
  assign ctl.cmp_val  = clk_cmp_q;
  assign ctl.cmp_wr   = wr_lo | wr_hi;

  assign reg_rdata_o                    = rdata_q;
  assign reg_rvalid_o                   = rvalid_q;
  assign run_list_go_o                  = ctl.honored;
  assign core_clk_stop_o                = ctl.clk_stop;
  assign draw_count_preset_o            = draw_q;
  assign snapshot_resume_o              = snap_q;
  assign vc_implicit_inhibit_o          = vf_q[rdrb_pkg::VF_INHIBIT_BIT];
  assign vertex_result_cache_disable_o  = vc_dis_q;
  assign fetch_bypass_cache_o           = vf_q[rdrb_pkg::VF_OFC_BIT];
  assign render_cache_ctl_cg_en_o       = eco_q[rdrb_pkg::ECO_RCC_CG_BIT];
  assign memory_writeback_unit_cg_en_o  = eco_q[rdrb_pkg::ECO_MEMORY_WRITEBACK_UNIT_CG_BIT];
  assign video_front_end_unit_fix_o     = eco_q[rdrb_pkg::ECO_VFE_FIX_BIT];
  assign const_buf_ctx_excl_o           = eco_q[rdrb_pkg::ECO_CBUF_BIT];
  assign thread_dispatch_unit_scr_fix_o = eco_q[rdrb_pkg::ECO_SCR_FIX_BIT];
  assign scratch_max_kb_o               = scr_max_q;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  // Write request shapes and the pulse-gone shape used below
  sequence s_vf_wr_nomask1;
    wr_vf && !reg_wdata_i[rdrb_pkg::MASK_SHIFT + rdrb_pkg::VF_OFC_BIT];
  endsequence

  sequence s_snap_wr;
    wr_vf && reg_wdata_i[31] && reg_wdata_i[15];
  endsequence

  sequence s_snap_gone;
    !snapshot_resume_o;
  endsequence

  // Zero delay honours a lone submission on the next edge
  chk_preempt_zero_go: assert property (
    (preempt_q == 10'h000 && run_list_submit_i) |=> run_list_go_o)
    else $error("submission held with zero delay");

  // Go is followed by at least eight quiet cycles while a delay is programmed
  chk_preempt_spaced: assert property (
    (run_list_go_o && preempt_q != 10'h000) |=> !run_list_go_o [*8])
    else $error("submissions too close");

  // Write to either compare word restarts the tick count
  chk_cmp_wr_clear: assert property (
    (wr_lo || wr_hi) |=> (ctl.tick_cnt == 64'h0 && !core_clk_stop_o))
    else $error("tick counter not cleared by compare write");

  // Reaching the armed compare stops the clock next edge
  chk_clk_stop_hit: assert property (
    (clk_cmp_q != 64'h0 && ctl.tick_cnt == clk_cmp_q && !ctl.cmp_wr) |=> core_clk_stop_o)
    else $error("clock not stopped at compare");

  // Unmasked bit 1 keeps its value
  chk_vf_mask_hold: assert property (
    s_vf_wr_nomask1 |=> $stable(fetch_bypass_cache_o))
    else $error("vertex scratch bit changed without mask");

  // Masked one on bit 15 gives exactly one release pulse when not repeated
  chk_snap_pulse: assert property (
    s_snap_wr ##1 !wr_snap |-> snapshot_resume_o ##1 s_snap_gone)
    else $error("snapshot release not a single pulse");

  // Writing zero to bit 15 releases nothing
  chk_snap_zero: assert property (
    (wr_vf && !reg_wdata_i[15]) |=> !snapshot_resume_o)
    else $error("snapshot released by zero write");

  // Unmasked gating bit keeps its value
  chk_eco_mask_hold: assert property (
    (wr_eco && !reg_wdata_i[rdrb_pkg::MASK_SHIFT + rdrb_pkg::ECO_RCC_CG_BIT])
      |=> $stable(render_cache_ctl_cg_en_o))
    else $error("scratch pad bit changed without mask");

  // Valid register reads the live flag in bit 0 only
  chk_cmdvld_read: assert property (
    (reg_rd_i && hit_cmdv) |=> (reg_rdata_o == {31'h00000000, $past(cmd_valid_i)}))
    else $error("command valid readback wrong");

  // Not one-hot flush state reads all ones
  chk_fsm_code: assert property (
    (reg_rd_i && hit_fsm && !$onehot(flush_fifo_state_i)) |=> reg_rdata_o[15:13] == 3'h7)
    else $error("flush fifo field not 111 for odd state");

  // Implicit disable obeys the inhibit bit
  chk_vc_disable: assert property (
    vc_implicit_inhibit_o |=> !vertex_result_cache_disable_o)
    else $error("cache disabled while inhibited");

  // Writes to live views leave every stored register alone
  chk_dbg_wr_ignored: assert property (
    (reg_wr_i && (hit_fsm || hit_flag || hit_track || hit_cmdw || hit_cmdv))
      |=> $stable(clk_cmp_q) && $stable(preempt_q) && $stable(draw_q) && $stable(vf_q)
          && $stable(eco_q))
    else $error("debug register write disturbed state");

  // Command word read returns the word seen at the strobe
  chk_cmdw_read: assert property (
    (reg_rd_i && hit_cmdw) |=> (reg_rdata_o == $past(cmd_word_i)))
    else $error("command word readback wrong");

  // Delay reads keep the reserved bits at zero
  chk_pre_rsvd_zero: assert property (
    (reg_rd_i && hit_pre) |=> (reg_rdata_o[31:10] == 22'h000000))
    else $error("delay reserved bits not zero");

  // Return-buffer clear state reads code 10
  chk_urb_code: assert property (
    (reg_rd_i && hit_fsm && unified_return_buffer_state_i == 4'h4)
      |=> (reg_rdata_o[9:8] == 2'h2))
    else $error("return buffer flush field wrong for clear state");

  // Null state of the 3D-control flush reads code 101
  chk_c3d_code: assert property (
    (reg_rd_i && hit_fsm && ctl3d_flush_state_i == 6'h20)
      |=> (reg_rdata_o[12:10] == 3'h5))
    else $error("3D-control flush field wrong for null state");

  // Size limit follows the fix bit one edge later
  chk_scr_fix_max: assert property (
    thread_dispatch_unit_scr_fix_o |=> (scratch_max_kb_o == rdrb_pkg::SCR_MAX_FIX_KB))
    else $error("scratch limit not raised by fix bit");

  // Without the fix the small limit applies
  chk_scr_base_max: assert property (
    !thread_dispatch_unit_scr_fix_o |=> (scratch_max_kb_o == rdrb_pkg::SCR_MAX_BASE_KB))
    else $error("scratch limit not small without fix bit");

endmodule

// >>> test/rdrb_tb.sv
// Self-checking bench for the render debug register bank
`timescale 1ns/1ns
module tb;
  // --------------------------------------------------------------
  // Stimulus and observation signals
  // --------------------------------------------------------------
  logic        core_clk_i = 1'b0;
  logic        srst_i     = 1'b1;
  logic [15:0] addr       = 16'h0000;
  logic [31:0] wdata      = 32'h00000000;
  logic        wr_s = 1'b0, rd_s = 1'b0, cmd_v = 1'b0, submit = 1'b0, elem = 1'b0;
  logic [31:0] rdata, cmd_w = 32'h00000000;
  logic        rvalid, go, stop, snap, inh, vcd, byp, render_cache_ctl, memory_writeback_unit, vfe, cbuf, sfix;
  logic [6:0]  fifo_st = 7'h01;
  logic [5:0]  st3d    = 6'h01;
  logic [3:0]  urb_st  = 4'h1, entry = 4'h0, nxt = 4'h0;
  logic [16:0] flags   = 17'h00000;
  logic [12:0] trk     = 13'h0000;
  logic [23:0] preset;
  logic [8:0]  kb;
  logic [31:0] exp_q[$];
  int          fail_count = 0, checked = 0, seed = 32'hD400, n, i;

  rdrb_top i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .flush_fifo_state_i(fifo_st), .ctl3d_flush_state_i(st3d),
    .unified_return_buffer_state_i(urb_st), .urb_entry_code_i(entry),
    .flush_next_code_i(nxt), .flush_flags_i(flags), .flush_track_i(trk),
    .cmd_word_i(cmd_w), .cmd_valid_i(cmd_v), .run_list_submit_i(submit),
    .run_list_go_o(go), .core_clk_stop_o(stop), .elem_seq_or_primid_i(elem),
    .draw_count_preset_o(preset), .snapshot_resume_o(snap), .vc_implicit_inhibit_o(inh),
    .vertex_result_cache_disable_o(vcd), .fetch_bypass_cache_o(byp),
    .render_cache_ctl_cg_en_o(render_cache_ctl), .memory_writeback_unit_cg_en_o(memory_writeback_unit),
    .video_front_end_unit_fix_o(vfe), .const_buf_ctx_excl_o(cbuf),
    .thread_dispatch_unit_scr_fix_o(sfix), .scratch_max_kb_o(kb));

  // Free-running core clock, 50 ns period
  initial forever #25 core_clk_i = ~core_clk_i;

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge core_clk_i);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge core_clk_i);
    wr_s = 1'b0;
  endtask
  // Expected read data goes into the queue; the watcher compares it later
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge core_clk_i);
    addr = a;
    rd_s = 1'b1;
    exp_q.push_back(e);
    @(negedge core_clk_i);
    rd_s = 1'b0;
  endtask
  // Pulses a submission and counts cycles until the go pulse; bounded wait
  task automatic run_list(output int cnt);
    @(negedge core_clk_i);
    submit = 1'b1;
    @(negedge core_clk_i);
    submit = 1'b0;
    cnt = 0;
    while (go !== 1'b1 && cnt < 200) begin
      @(negedge core_clk_i);
      cnt++;
    end
    if (cnt >= 200) begin
      fail_count++;
      $display("[FAIL] %0t run list go never came", $time);
      wrap_up();
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Read watcher: oldest expectation against each answer, sampled mid-cycle
  always @(negedge core_clk_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(rdata, 32'hDEADBEEF);
      else chk(rdata, exp_q.pop_front());
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(negedge core_clk_i);
    srst_i = 1'b0;
    chk(32'(kb), 32'h0000000C);
    rd(16'h2214, 32'h0);
    rd(16'h2360, 32'h0);
    rd(16'h2470, 32'h0);
    rd(16'h21D0, 32'h0);
    rd(16'h2FFC, 32'h0);
    wr(16'h2200, 32'hFFFFFFFF);
    // Every one-hot code, then an invalid mix that must read all ones
    for (i = 0; i < 8; i++) begin
      fifo_st = (i == 7) ? 7'h03 : 7'(1 << i);
      st3d = (i == 7) ? 6'h00 : 6'(1 << (i % 6));
      urb_st = (i == 7) ? 4'h0 : 4'(1 << (i % 4));
      entry = 4'($random(seed));
      nxt = 4'($random(seed));
      rd(16'h2200, {16'h0, (i == 7) ? 3'h7 : 3'(i), (i == 7) ? 3'h7 : 3'(i % 6),
                    (i == 7) ? 2'h3 : 2'(i % 4), entry, nxt});
    end
    flags = 17'($random(seed));
    trk = 13'($random(seed));
    cmd_w = $random(seed);
    cmd_v = 1'b1;
    rd(16'h2204, {15'h0, flags});
    rd(16'h2208, {19'h0, trk});
    rd(16'h220C, cmd_w);
    rd(16'h2210, 32'h1);
    // Zero delay: back-to-back submissions go at once
    run_list(n);
    chk(32'(n), 32'h0);
    run_list(n);
    chk(32'(n), 32'h0);
    wr(16'h2214, 32'hFFFFFC01);
    rd(16'h2214, 32'h1);
    run_list(n);
    run_list(n);
    chk(32'(n >= 39 && n <= 42), 32'h1);
    // Compare of 3 raises stop four cycles after the write; rewrite restarts it
    for (i = 0; i < 2; i++) begin
      wr(i == 0 ? 16'h2360 : 16'h2364, i == 0 ? 32'h3 : 32'h0);
      chk(32'(stop), 32'h0);
      n = 0;
      while (stop !== 1'b1 && n < 20) begin
        @(negedge core_clk_i);
        n++;
      end
      chk(32'(n), 32'h4);
    end
    wdata = $random(seed);
    wr(16'h2450, wdata);
    chk(32'(preset), {8'h0, wdata[23:0]});
    rd(16'h2450, {8'h0, wdata[23:0]});
    // Vertex-fetch scratch: masked bits only, bit 15 pulses once
    elem = 1'b1;
    wr(16'h2470, 32'h00000006);
    chk({29'h0, vcd, inh, byp}, 32'h4);
    wr(16'h2470, 32'h80068006);
    chk({29'h0, snap, inh, byp}, 32'h7);
    @(negedge core_clk_i);
    chk({30'h0, snap, vcd}, 32'h0);
    wr(16'h2470, 32'h00008000);
    chk(32'(snap), 32'h0);
    rd(16'h2470, 32'h6);
    // Engineering scratch pad: implemented bits only, under mask
    wr(16'h21D0, 32'h01B8FFFF);
    @(negedge core_clk_i);
    chk({23'h0, kb}, 32'h100);
    chk({27'h0, render_cache_ctl, memory_writeback_unit, vfe, cbuf, sfix}, 32'h1F);
    wr(16'h21D0, 32'h00000000);
    wr(16'h21D0, 32'h00980000);
    rd(16'h21D0, 32'h120);
    @(negedge core_clk_i);
    chk({18'h0, kb, render_cache_ctl, memory_writeback_unit, vfe, cbuf, sfix}, 32'h194);
    // Mid-run reset returns every control to its reset value
    srst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    srst_i = 1'b0;
    chk({17'h0, kb, render_cache_ctl, memory_writeback_unit, vfe, cbuf, sfix, stop}, 32'h300);
    rd(16'h21D0, 32'h0);
    n = 0;
    while (exp_q.size() != 0 && n < 20) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      $display("[FAIL] %0t read answers missing", $time);
    end
    wrap_up();
  end
endmodule
